// ---- rtl/timer_irq_enable_set_clear.sv ----
/*
 * Interrupt-enable mask of a control timer, reached through a clear port
 * and a set port, with sticky flags, write protection and one irq line.
 * Assumes a plain register port: one-cycle strobes, read data next cycle.
 */
// The implementer's own choice: the strobed register port.
// What this block does
// - one mask, seen and changed through both clear and set ports
// - single write changes selected bits; others keep their value
// - reserved bits 31:20 and 10:4 read zero, hold nothing
// - writing zero to any enable bit leaves it unchanged
// - reads return one per enabled source, zero per disabled
// - clear port bits 19:16 disable channel match/capture irqs
// - set port bits 19:16 enable channel match/capture irqs
// - clear port bits 15,14 disable hard faults one and zero
// - set port bits 15,14 enable hard faults one and zero
// - clear port bits 13,12 disable soft faults b and a
// - set port bits 13,12 enable soft faults b and a
// - clear port bit 11 disables debug fault state irq
// - set port bit 11 enables debug fault state irq
// - clear port bits 3..0 disable error, counter, retrigger, overflow
// - set port bits 3..0 enable error, counter, retrigger, overflow
`timescale 1ns/100ps
`default_nettype none
module timer_irq_enable_set_clear #(
    parameter int unsigned MC_NUM = irq_enable_pkg::MC_NUM // channels
) (
    input wire logic ref_clk_i,          // 40 MHz clock
    input wire logic rstn_i,             // async reset, low
    input wire logic [7:0] addr_i,       // register byte address
    input wire logic [31:0] wdata_i,     // write data
    input wire logic wr_i,               // write strobe
    input wire logic rd_i,               // read strobe
    output logic [31:0] rdata_o,         // read data, cycle after rd_i
    input wire logic [MC_NUM-1:0] mc_evt_i, // channel match/capture pulses
    input wire logic hard_fault_one_evt_i,  // hard fault one pulse
    input wire logic hard_fault_zero_evt_i, // hard fault zero pulse
    input wire logic soft_fault_b_evt_i,    // soft fault b pulse
    input wire logic soft_fault_a_evt_i,    // soft fault a pulse
    input wire logic debug_fault_evt_i,     // debug fault state pulse
    input wire logic error_evt_i,           // capture lost pulse
    input wire logic counter_evt_i,         // counter cycle pulse
    input wire logic retrigger_evt_i,       // retrigger pulse
    input wire logic overflow_evt_i,        // overflow pulse
    output logic [19:0] irq_enable_o,       // current mask
    output logic irq_o                      // level interrupt
);
    // ==========================================================
    // request decode
    irq_enable_pkg::reg_req_t req;
    irq_enable_pkg::mask_upd_t upd;
    logic wr_clr;
    logic wr_set;
    logic wr_wp;
    logic rd_flag;
    logic wp_q;
    logic [31:0] rdata_d;
    logic [31:0] evt_word;
    logic [19:0] evt_bits;
    logic [19:0] flag_q;
    logic [19:0] mask_q;
    logic [19:0] impl_bits;

    assign req.wr = wr_i;
    assign req.rd = rd_i;
    assign req.addr = addr_i;
    assign req.wdata = wdata_i;
    assign impl_bits = irq_enable_pkg::IMPL_MASK[19:0];

    always_comb begin
        wr_clr = 1'b0;
        wr_set = 1'b0;
        wr_wp = 1'b0;
        if (req.wr && req.addr == irq_enable_pkg::OFFS_ENABLE_CLEAR) begin
            wr_clr = ~wp_q;
        end else if (req.wr &&
                     req.addr == irq_enable_pkg::OFFS_ENABLE_SET) begin
            wr_set = ~wp_q;
        end else if (req.wr &&
                     req.addr == irq_enable_pkg::OFFS_WRITE_PROTECT) begin
            wr_wp = 1'b1;
        end
    end

    // only ones select bits; reserved positions are masked off, so stray
    // ones there cannot create state
    assign upd.clr_bits = wr_clr ? (req.wdata[19:0] & impl_bits)
                                 : 20'h0_0000;
    assign upd.set_bits = wr_set ? (req.wdata[19:0] & impl_bits)
                                 : 20'h0_0000;

    // ==========================================================
    // write protection
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wp_q <= irq_enable_pkg::WP_RESET;
        end else if (wr_wp) begin
            wp_q <= req.wdata[irq_enable_pkg::WP_BIT];
        end
    end

    // ==========================================================
    // shared mask, one cell per implemented bit
    genvar gi;
    generate
        for (gi = 0; gi < irq_enable_pkg::MASK_W; gi++) begin : g_bits
            if (irq_enable_pkg::IMPL_MASK[gi]) begin : g_impl
                irq_mask_bit u_mask (
                    .ref_clk_i(ref_clk_i),
                    .rstn_i(rstn_i),
                    .set_i(upd.set_bits[gi]),
                    .clr_i(upd.clr_bits[gi]),
                    .q_o(mask_q[gi])
                );
                irq_sticky_bit u_flag (
                    .ref_clk_i(ref_clk_i),
                    .rstn_i(rstn_i),
                    .set_i(evt_bits[gi]),
                    .clr_i(rd_flag),
                    .q_o(flag_q[gi])
                );
            end else begin : g_rsvd
                assign mask_q[gi] = 1'b0;
                assign flag_q[gi] = 1'b0;
            end
        end
    endgenerate
    // bit cells cover 11 (debug) 3..0 via the same path

    // ==========================================================
    // event mapping
    always_comb begin
        evt_word = 32'h0000_0000;
        evt_word[irq_enable_pkg::BIT_MC_LSB +: MC_NUM] = mc_evt_i;
        evt_word[irq_enable_pkg::BIT_HARD_FAULT_ONE] = hard_fault_one_evt_i;
        evt_word[irq_enable_pkg::BIT_HARD_FAULT_ZERO] = hard_fault_zero_evt_i;
        evt_word[irq_enable_pkg::BIT_SOFT_FAULT_B] = soft_fault_b_evt_i;
        evt_word[irq_enable_pkg::BIT_SOFT_FAULT_A] = soft_fault_a_evt_i;
        evt_word[irq_enable_pkg::BIT_DEBUG_FAULT] = debug_fault_evt_i;
        evt_word[irq_enable_pkg::BIT_ERROR] = error_evt_i;
        evt_word[irq_enable_pkg::BIT_COUNTER] = counter_evt_i;
        evt_word[irq_enable_pkg::BIT_RETRIGGER] = retrigger_evt_i;
        evt_word[irq_enable_pkg::BIT_OVERFLOW] = overflow_evt_i;
    end
    assign evt_bits = evt_word[19:0] & impl_bits;

    assign rd_flag = req.rd && req.addr == irq_enable_pkg::OFFS_FLAG_STATUS;

    // ==========================================================
    // read path
    always_comb begin
        rdata_d = irq_enable_pkg::READ_UNMAPPED;
        if (req.addr == irq_enable_pkg::OFFS_ENABLE_CLEAR) begin
            rdata_d = {12'h000, mask_q};
        end else if (req.addr == irq_enable_pkg::OFFS_ENABLE_SET) begin
            rdata_d = {12'h000, mask_q};
        end else if (req.addr == irq_enable_pkg::OFFS_FLAG_STATUS) begin
            rdata_d = {12'h000, flag_q};
        end else if (req.addr == irq_enable_pkg::OFFS_WRITE_PROTECT) begin
            rdata_d = {31'h0000_0000, wp_q};
        end
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (req.rd) begin
            rdata_o <= rdata_d;
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end

    // ==========================================================
    // outputs
    assign irq_enable_o = mask_q;
    assign irq_o = |(flag_q & mask_q);
endmodule : timer_irq_enable_set_clear
`default_nettype wire

// ---- include/irq_enable_pkg.sv ----
/*
 * Package for the timer interrupt-enable register bank: offsets, masks,
 * bit positions, bus carrier structs.
 * Assumes a 32-bit register port with byte addresses.
 */
package irq_enable_pkg;
    // ==========================================================
    // widths
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned MASK_W = 20;
    localparam int unsigned MC_NUM = 4;

    // ==========================================================
    // register offsets
    localparam logic [7:0] OFFS_ENABLE_CLEAR = 8'h24;
    localparam logic [7:0] OFFS_ENABLE_SET = 8'h28;
    localparam logic [7:0] OFFS_FLAG_STATUS = 8'h2c;
    localparam logic [7:0] OFFS_WRITE_PROTECT = 8'h40;

    // ==========================================================
    // field positions
    localparam int unsigned BIT_OVERFLOW = 0;
    localparam int unsigned BIT_RETRIGGER = 1;
    localparam int unsigned BIT_COUNTER = 2;
    localparam int unsigned BIT_ERROR = 3;
    localparam int unsigned BIT_DEBUG_FAULT = 11;
    localparam int unsigned BIT_SOFT_FAULT_A = 12;
    localparam int unsigned BIT_SOFT_FAULT_B = 13;
    localparam int unsigned BIT_HARD_FAULT_ZERO = 14;
    localparam int unsigned BIT_HARD_FAULT_ONE = 15;
    localparam int unsigned BIT_MC_LSB = 16;

    // implemented bits: 19:11 and 3:0, everything else reads zero
    localparam logic [31:0] IMPL_MASK = 32'h000f_f80f;
    localparam logic [19:0] MASK_RESET = 20'h0_0000;
    localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;
    localparam logic WP_RESET = 1'b0;
    localparam int unsigned WP_BIT = 0;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [19:0] set_bits;
        logic [19:0] clr_bits;
    } mask_upd_t;
endpackage : irq_enable_pkg

// ---- rtl/irq_sticky_bit.sv ----
/*
 * One sticky status bit: hardware set beats read-clear.
 * Assumes a single clock and active-low asynchronous reset.
 */
`timescale 1ns/100ps
`default_nettype none
module irq_sticky_bit (
    input wire logic ref_clk_i, // clock
    input wire logic rstn_i,    // async reset, low
    input wire logic set_i,     // event pulse
    input wire logic clr_i,     // clear on read
    output logic q_o            // sticky state
);
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q_o <= 1'b0;
        end else if (set_i) begin
            q_o <= 1'b1;
        end else if (clr_i) begin
            q_o <= 1'b0;
        end
    end
endmodule : irq_sticky_bit
`default_nettype wire

// ---- rtl/irq_mask_bit.sv ----
/*
 * One enable bit of the shared mask, with set and clear strobes.
 * Assumes set and clear come from separate ports, never both high.
 */
`timescale 1ns/100ps
`default_nettype none
module irq_mask_bit (
    input wire logic ref_clk_i, // clock
    input wire logic rstn_i,    // async reset, low
    input wire logic set_i,     // enable strobe
    input wire logic clr_i,     // disable strobe
    output logic q_o            // enable state
);
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q_o <= 1'b0;
        end else if (set_i) begin
            q_o <= 1'b1;
        end else if (clr_i) begin
            q_o <= 1'b0;
        end
    end
endmodule : irq_mask_bit
`default_nettype wire

// ---- dv/irq_enable_chk.sv ----
/* Checker for the interrupt-enable mask ports, bound to the top module.
   Assumes one clock and the protect bit at 0x40 bit 0. */
`timescale 1ns/100ps
`default_nettype none
module irq_enable_chk (
    input wire logic ref_clk_i, // clock
    input wire logic rstn_i, // async reset, low
    input wire logic [7:0] addr_i, // address
    input wire logic [31:0] wdata_i, // write data
    input wire logic wr_i, // write strobe
    input wire logic rd_i, // read strobe
    input wire logic [31:0] rdata_o, // read data
    input wire logic [19:0] irq_enable_o, // mask
    input wire logic irq_o // interrupt
);
    // ==========================================================
    // helpers
    localparam logic [19:0] IMPL = 20'hff80f;
    logic wp_q;
    logic wr_set;
    logic wr_clr;
    assign wr_set = wr_i && addr_i == 8'h28;
    assign wr_clr = wr_i && addr_i == 8'h24;
    // protect state mirrored here, the port does not show it
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i)
            wp_q <= 1'b0;
        else if (wr_i && addr_i == 8'h40)
            wp_q <= wdata_i[0];
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    // ==========================================================
    // assertions
    chk_set_port_bits: assert property (wr_set && !wp_q |=>
        (irq_enable_o & $past(wdata_i[19:0]) & IMPL)
        == ($past(wdata_i[19:0]) & IMPL)) else $error("set write missed");
    chk_clr_port_bits: assert property (wr_clr && !wp_q |=>
        (irq_enable_o & $past(wdata_i[19:0])) == 20'h0)
        else $error("clear write missed");
    chk_others_kept: assert property ((wr_set || wr_clr) |=>
        ((irq_enable_o ^ $past(irq_enable_o)) & ~$past(wdata_i[19:0]))
        == 20'h0) else $error("unselected bit changed");
    chk_idle_stable: assert property (!(wr_set || wr_clr) |=>
        $stable(irq_enable_o)) else $error("mask changed without write");
    chk_protect_hold: assert property ((wr_set || wr_clr) && wp_q
        |=> $stable(irq_enable_o)) else $error("protected write took");
    chk_read_mirror: assert property (rd_i && (addr_i == 8'h24
        || addr_i == 8'h28) |=> rdata_o == {12'h0, $past(irq_enable_o)})
        else $error("read data differs from mask");
    chk_reserved_zero: assert property (irq_enable_o[10:4] == 7'h0)
        else $error("reserved mask bits set");
    chk_reset_clear: assert property ($rose(rstn_i) |->
        irq_enable_o == 20'h0) else $error("mask not clear after reset");
    chk_irq_masked: assert property (irq_o |-> irq_enable_o != 20'h0)
        else $error("irq with empty mask");
    cov_set: cover property (wr_set && !wp_q);
    cov_protect: cover property (wr_clr && wp_q);
    cov_irq: cover property ($rose(irq_o));
endmodule : irq_enable_chk
bind timer_irq_enable_set_clear irq_enable_chk u_irq_enable_chk (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .irq_enable_o(irq_enable_o), .irq_o(irq_o));
`default_nettype wire

// ---- dv/tb.sv ----
/* Self-checking bench for the interrupt-enable mask register bank.
   Assumes the register port of the notes and flags read-cleared at 0x2c. */
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic ref_clk_i, rstn_i, wr_i, rd_i, irq_o;
    logic [7:0] addr_i;
    logic [31:0] wdata_i, rdata_o;
    logic [19:0] evt, irq_enable_o, acc;
    int err_total, checks_done, cyc;
    timer_irq_enable_set_clear u_timer_irq_enable_set_clear (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .mc_evt_i(evt[19:16]), .hard_fault_one_evt_i(evt[15]),
        .hard_fault_zero_evt_i(evt[14]), .soft_fault_b_evt_i(evt[13]),
        .soft_fault_a_evt_i(evt[12]), .debug_fault_evt_i(evt[11]),
        .error_evt_i(evt[3]), .counter_evt_i(evt[2]),
        .retrigger_evt_i(evt[1]), .overflow_evt_i(evt[0]),
        .irq_enable_o(irq_enable_o), .irq_o(irq_o));
    // ==========================================================
    // tasks
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge ref_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        #1;
    endtask : wr
    // read data stand one cycle only, so sample just after that edge
    task automatic rd(logic [7:0] a, logic [31:0] exp);
        @(posedge ref_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1;
        chk("rdata", exp, rdata_o);
    endtask : rd
    task automatic pulse(logic [19:0] v);
        @(posedge ref_clk_i);
        evt <= v;
        @(posedge ref_clk_i);
        evt <= 20'h0;
        #1;
    endtask : pulse
    // ==========================================================
    // clock, timeout, tests
    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            $display("Error timeout expected end seen hang");
            close_out();
        end
    end
    initial begin
        {rstn_i, wr_i, rd_i, addr_i, wdata_i, evt, acc} = '0;
        repeat (20) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        rd(8'h24, 32'h0);
        rd(8'h28, 32'h0);
        rd(8'h3c, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 20; i++) if (irq_enable_pkg::IMPL_MASK[i]) begin
            acc[i] = 1'b1;
            wr(8'h28, 32'h1 << i);
            chk("set", acc, irq_enable_o);
            chk("set", acc, irq_enable_o);
            rd(8'h24, acc);
        end
        for (int i = 0; i < 20; i++) if (irq_enable_pkg::IMPL_MASK[i]) begin
            acc[i] = 1'b0;
            wr(8'h24, 32'h1 << i);
            rd(8'h28, acc);
            rd(8'h24, acc);
        end
        $display("test per bit done");
        wr(8'h28, 32'h000f_f80f);
        rd(8'h28, 32'h000f_f80f);
        wr(8'h24, 32'h0000_0000);
        rd(8'h24, 32'h000f_f80f);
        wr(8'h24, 32'h000f_f80f);
        $display("test reserved done");
        wr(8'h40, 32'h1);
        wr(8'h28, 32'h000f_f80f);
        rd(8'h28, 32'h0);
        wr(8'h40, 32'h0);
        wr(8'h28, 32'h0000_0001);
        rd(8'h24, 32'h1);
        wr(8'h40, 32'h1);
        wr(8'h24, 32'h0000_0001);
        rd(8'h24, 32'h1);
        wr(8'h40, 32'h0);
        $display("test protect done");
        pulse(20'h00001);
        chk("irq", 32'h1, {31'h0, irq_o});
        rd(8'h2c, 32'h1);
        chk("irq", 32'h0, {31'h0, irq_o});
        pulse(20'h10004);
        chk("irq masked", 32'h0, {31'h0, irq_o});
        wr(8'h28, 32'h0001_0000);
        chk("irq late", 32'h1, {31'h0, irq_o});
        rd(8'h2c, 32'h0001_0004);
        $display("test irq done");
        close_out();
    end
endmodule : tb
`default_nettype wire
